// *** hw/hpc_top.sv ***
// host port core-side control, pin configuration and data path
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
module hpc_top (
	input  wire  logic        core_clk,
	input  wire  logic        resetn,
	input  wire  logic [4:0]  avs_address,
	input  wire  logic        avs_read,
	input  wire  logic        avs_write,
	input  wire  logic [31:0] avs_writedata,
	input  wire  logic [3:0]  avs_byteenable,
	output var   logic [31:0] avs_readdata,
	output var   logic        avs_waitrequest,
	input  wire  logic [7:0]  host_data_in,
	output var   logic [7:0]  host_data_out,
	output var   logic        host_data_oe,
	input  wire  logic        host_addr_in,
	input  wire  logic        host_rw_in,
	input  wire  logic        chip_select_pin,
	input  wire  logic        addr_strobe_pin,
	input  wire  logic        data_strobe_pin,
	input  wire  logic        read_strobe_pin,
	input  wire  logic        write_strobe_pin,
	input  wire  logic        host_ack_in,
	input  wire  logic        host_cmd_in,
	output var   logic        host_request_out,
	output var   logic        host_request_oe,
	output var   logic [4:0]  pin_host_fn,
	output var   logic        port_gpio_enable,
	output var   logic [1:0]  irq_vector,
	output var   logic        irq
);
	logic                        rst_s1_reg;
	logic                        rst_n;
	logic [7:0]                  ctrl_reg;
	logic [15:0]                 pc_reg;
	logic                        core_rx_full;
	logic                        core_tx_empty;
	logic                        command_pending;
	logic [23:0]                 rx_data_reg;
	logic [23:0]                 rx_shift_reg;
	logic [23:0]                 tx_data_reg;
	logic [1:0]                  rx_cnt_reg;
	logic [1:0]                  tx_cnt_reg;
	logic [2:0]                  irq_stat_reg;
	logic [2:0]                  irq_mask_reg;
	logic [2:0]                  irq_lvl_reg;
	logic                        haddr_reg;
	logic                        rd_act_reg;
	logic                        wr_act_reg;
	logic                        dma_act_reg;
	logic                        as_act_reg;
	logic                        cmd_pin_reg;
	logic [hpc_pkg::SYNC_W-1:0] pins_s;
	logic [1:0]                  prio_code;

	// decode helpers
	function automatic logic pin_active(input logic pin, input logic pol);
		pin_active = pin ~^ pol;
	endfunction

	function automatic logic [1:0] word_bytes(input logic [2:0] mode);
		word_bytes = (mode[1:0] == 2'h0) ? 2'h3 : 2'h3 - mode[1:0] + 2'h1;
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
	                                         input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			be_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// reset release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	hpc_sync3 #(
		.W (hpc_pkg::SYNC_W)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in ({host_cmd_in, host_ack_in, write_strobe_pin, read_strobe_pin,
		            data_strobe_pin, addr_strobe_pin, chip_select_pin, host_rw_in,
		            host_addr_in, host_data_in}),
		.sync_out (pins_s)
	);

	wire [7:0] hd_s  = pins_s[7:0];
	wire       ha_s  = pins_s[8];
	wire       rw_s  = pins_s[9];
	wire       cs_s  = pins_s[10];
	wire       as_s  = pins_s[11];
	wire       ds_s  = pins_s[12];
	wire       rd_s  = pins_s[13];
	wire       wr_s  = pins_s[14];
	wire       ack_s = pins_s[15];
	wire       cmd_s = pins_s[16];

	// configuration seen by the pins, masked while disabled
	wire       port_en  = pc_reg[hpc_pkg::PC_PORT_EN];
	wire       mux_en   = port_en & pc_reg[hpc_pkg::PC_MUX];
	wire       dual_en  = port_en & pc_reg[hpc_pkg::PC_DUAL];
	wire       ds_pol   = port_en & pc_reg[hpc_pkg::PC_DS_POL];
	wire       as_pol   = port_en & pc_reg[hpc_pkg::PC_AS_POL];
	wire       cs_pol   = port_en & pc_reg[hpc_pkg::PC_CS_POL];
	wire       req_pol  = port_en & pc_reg[hpc_pkg::PC_REQ_POL];
	wire       ack_pol  = port_en & pc_reg[hpc_pkg::PC_ACK_POL];
	wire       req_od   = port_en & pc_reg[hpc_pkg::PC_REQ_OD];
	wire       a8_fn    = port_en & (~mux_en | pc_reg[hpc_pkg::PC_A8_EN]);
	wire       a9_fn    = port_en & (~mux_en | pc_reg[hpc_pkg::PC_A9_EN]);
	wire       cs_fn    = port_en & pc_reg[hpc_pkg::PC_CS_EN];
	wire       req_fn   = port_en & pc_reg[hpc_pkg::PC_REQ_EN];
	wire       ack_fn   = req_fn & pc_reg[hpc_pkg::PC_ACK_EN];

	wire [2:0] dma_mode = ctrl_reg[hpc_pkg::CTRL_DMA_LSB +: 3];
	wire       dma_xfer = dma_mode[1:0] != 2'h0;
	wire       c2h_only = dma_xfer & dma_mode[2];
	wire       h2c_only = dma_xfer & ~dma_mode[2];
	wire [1:0] nbytes   = word_bytes(dma_mode);

	// host strobes
	wire       cs_ok    = ~cs_fn | pin_active(cs_s, cs_pol);
	wire       ds_act   = pin_active(ds_s, ds_pol);
	wire       rd_raw   = dual_en ? pin_active(rd_s, ds_pol) : (ds_act & rw_s);
	wire       wr_raw   = dual_en ? pin_active(wr_s, ds_pol) : (ds_act & ~rw_s);
	wire       rd_act   = port_en & cs_ok & rd_raw;
	wire       wr_act   = port_en & cs_ok & wr_raw;
	wire       as_act   = port_en & mux_en & pin_active(as_s, as_pol);
	wire       dma_act  = ack_fn & dma_xfer & pin_active(ack_s, ack_pol);
	wire       haddr    = mux_en ? haddr_reg : ha_s;
	wire       rd_start = rd_act & ~rd_act_reg;
	wire       wr_start = wr_act & ~wr_act_reg;
	wire       dma_go   = dma_act & ~dma_act_reg;
	wire       host_rd  = (rd_start & ~dma_xfer & haddr == hpc_pkg::HADDR_DATA) |
	                      (dma_go & c2h_only);
	wire       host_wr  = (wr_start & ~dma_xfer & haddr == hpc_pkg::HADDR_DATA) |
	                      (dma_go & h2c_only);
	wire       flag_rd  = rd_start & haddr == hpc_pkg::HADDR_FLAGS;
	wire       rd_byte  = host_rd & ~core_tx_empty;
	wire       wr_byte  = host_wr & ~core_rx_full;
	wire       rx_done  = wr_byte & (rx_cnt_reg == nbytes - 2'h1);
	wire       tx_done  = rd_byte & (tx_cnt_reg == nbytes - 2'h1);
	wire [1:0] tx_sel   = nbytes - 2'h1 - tx_cnt_reg;
	wire [7:0] tx_byte  = tx_data_reg[8*tx_sel +: 8];
	wire [23:0] rx_word = {rx_shift_reg[15:0], hd_s};
	wire [23:0] rx_mask = (nbytes == 2'h3) ? 24'hffffff :
	                      (nbytes == 2'h2) ? 24'h00ffff : 24'h0000ff;
	wire       cmd_rise = cmd_s & ~cmd_pin_reg;

	// request level and drive
	wire       req_lvl  = dma_xfer ? (c2h_only ? ~core_tx_empty : ~core_rx_full) :
	                      (~core_tx_empty | ~core_rx_full);
	wire       req_val  = pin_active(req_lvl, req_pol);
	wire       req_out_next = req_od ? 1'b0 : req_val;
	wire       req_oe_next  = req_fn & (~req_od | ~req_val);

	// register bus decode
	wire       bus_req  = (avs_read | avs_write) & avs_waitrequest;
	wire       wr_acc   = avs_write & ~avs_waitrequest;
	wire       rd_acc   = avs_read & ~avs_waitrequest;
	wire       sel_ctrl = avs_address == hpc_pkg::OFS_CTRL;
	wire       sel_pc   = avs_address == hpc_pkg::OFS_PINCTRL;
	wire       sel_st   = avs_address == hpc_pkg::OFS_STATUS;
	wire       sel_rx   = avs_address == hpc_pkg::OFS_RXDATA;
	wire       sel_tx   = avs_address == hpc_pkg::OFS_TXDATA;
	wire       sel_is   = avs_address == hpc_pkg::OFS_IRQ_STAT;
	wire       sel_im   = avs_address == hpc_pkg::OFS_IRQ_MASK;
	wire       sel_vec  = avs_address == hpc_pkg::OFS_VECTOR;
	wire [31:0] wmerge_ctrl = be_merge({24'h0, ctrl_reg}, avs_writedata, avs_byteenable);
	wire [31:0] wmerge_pc   = be_merge({16'h0, pc_reg}, avs_writedata, avs_byteenable);
	wire [31:0] wmerge_tx   = be_merge({8'h0, tx_data_reg}, avs_writedata, avs_byteenable);
	wire       w1c_ok   = wr_acc & avs_byteenable[0];
	wire       cmd_clr  = w1c_ok & sel_st & avs_writedata[hpc_pkg::ST_CMD];
	wire       rx_pop   = rd_acc & sel_rx;
	wire       tx_load  = wr_acc & sel_tx;
	wire [2:0] st_vec   = {command_pending, core_tx_empty, core_rx_full};
	wire [2:0] lvl_now  = st_vec & {ctrl_reg[hpc_pkg::CTRL_CMD_IE],
	                                ctrl_reg[hpc_pkg::CTRL_TX_IE], ctrl_reg[hpc_pkg::CTRL_RX_IE]};
	wire [2:0] irq_set  = lvl_now & ~irq_lvl_reg;
	wire [2:0] irq_clr  = (w1c_ok & sel_is) ? avs_writedata[2:0] : 3'h0;
	wire [31:0] rd_mux  = sel_ctrl ? {24'h0, ctrl_reg} :
	                      sel_pc   ? {16'h0, pc_reg & hpc_pkg::PC_WMASK} :
	                      sel_st   ? {29'h0, st_vec} :
	                      sel_rx   ? {8'h0, rx_data_reg} :
	                      sel_tx   ? {8'h0, tx_data_reg} :
	                      sel_is   ? {29'h0, irq_stat_reg} :
	                      sel_im   ? {29'h0, irq_mask_reg} :
	                      sel_vec  ? {30'h0, irq_vector} : 32'h0;

	hpc_irq_prio u_prio (
		.irq_req  (lvl_now),
		.irq_code (prio_code)
	);

	// bus slave: one wait cycle, then the accepting edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else begin
			avs_waitrequest <= ~bus_req;
			if (avs_read & avs_waitrequest)
				avs_readdata <= rd_mux;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= hpc_pkg::CTRL_RESET;
			pc_reg       <= hpc_pkg::PC_RESET;
			irq_mask_reg <= 3'h0;
			tx_data_reg  <= 24'h0;
		end else if (wr_acc) begin
			if (sel_ctrl) ctrl_reg <= wmerge_ctrl[7:0] & hpc_pkg::CTRL_WMASK;
			if (sel_pc) pc_reg <= wmerge_pc[15:0] & hpc_pkg::PC_WMASK;
			if (sel_im & avs_byteenable[0]) irq_mask_reg <= avs_writedata[2:0];
			if (sel_tx) tx_data_reg <= wmerge_tx[23:0];
		end
	end

	// core-side flags; hardware set wins over software clear for rx full and command, tx_load wins over tx_done for tx empty
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_rx_full    <= 1'b0;
			core_tx_empty   <= 1'b1;
			command_pending <= 1'b0;
		end else begin
			core_rx_full    <= rx_done | (core_rx_full & ~rx_pop);
			core_tx_empty   <= ~tx_load & (tx_done | core_tx_empty);
			command_pending <= cmd_rise | (command_pending & ~cmd_clr);
		end
	end

	// host byte path
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_shift_reg <= 24'h0;
			rx_data_reg  <= 24'h0;
			rx_cnt_reg   <= 2'h0;
			tx_cnt_reg   <= 2'h0;
		end else begin
			if (wr_byte) begin
				rx_shift_reg <= rx_word;
				rx_cnt_reg   <= rx_done ? 2'h0 : rx_cnt_reg + 2'h1;
			end
			if (rx_done) rx_data_reg <= rx_word & rx_mask;
			if (tx_load) tx_cnt_reg <= 2'h0;
			else if (rd_byte) tx_cnt_reg <= tx_done ? 2'h0 : tx_cnt_reg + 2'h1;
		end
	end

	// pin side state and registered outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_act_reg       <= 1'b0;
			wr_act_reg       <= 1'b0;
			dma_act_reg      <= 1'b0;
			as_act_reg       <= 1'b0;
			haddr_reg        <= 1'b0;
			cmd_pin_reg      <= 1'b0;
			host_data_out    <= 8'h0;
			host_data_oe     <= 1'b0;
			host_request_out <= 1'b0;
			host_request_oe  <= 1'b0;
			pin_host_fn      <= 5'h0;
			port_gpio_enable <= 1'b0;
		end else begin
			rd_act_reg       <= rd_act;
			wr_act_reg       <= wr_act;
			dma_act_reg      <= dma_act;
			as_act_reg       <= as_act;
			cmd_pin_reg      <= cmd_s;
			if (as_act & ~as_act_reg) haddr_reg <= hd_s[0];
			if (rd_byte) host_data_out <= tx_byte;
			else if (flag_rd)
				host_data_out <= {3'h0, ctrl_reg[hpc_pkg::CTRL_FLAG_B],
				                  ctrl_reg[hpc_pkg::CTRL_FLAG_A], command_pending,
				                  core_tx_empty, core_rx_full};
			host_data_oe     <= rd_act | (dma_act & c2h_only);
			host_request_out <= req_out_next;
			host_request_oe  <= req_oe_next;
			pin_host_fn      <= {ack_fn, req_fn, cs_fn, a9_fn, a8_fn};
			port_gpio_enable <= pc_reg[hpc_pkg::PC_GPIO_EN];
		end
	end

	// interrupt status, mask and priority
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_lvl_reg  <= 3'h0;
			irq_stat_reg <= 3'h0;
			irq_vector   <= hpc_pkg::VEC_NONE;
			irq          <= 1'b0;
		end else begin
			irq_lvl_reg  <= lvl_now;
			irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
			irq_vector   <= prio_code;
			irq          <= |((irq_set | (irq_stat_reg & ~irq_clr)) & irq_mask_reg);
		end
	end
endmodule // hpc_top
`default_nettype wire

// *** hw/hpc_pkg.sv ***
// constants for the host port core-side configuration block
package hpc_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_CTRL     = 5'h00;
	localparam logic [4:0] OFS_PINCTRL  = 5'h04;
	localparam logic [4:0] OFS_STATUS   = 5'h08;
	localparam logic [4:0] OFS_RXDATA   = 5'h0c;
	localparam logic [4:0] OFS_TXDATA   = 5'h10;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
	localparam logic [4:0] OFS_VECTOR   = 5'h1c;
	// control register fields
	localparam int CTRL_RX_IE   = 0;
	localparam int CTRL_TX_IE   = 1;
	localparam int CTRL_CMD_IE  = 2;
	localparam int CTRL_FLAG_A  = 3;
	localparam int CTRL_FLAG_B  = 4;
	localparam int CTRL_DMA_LSB = 5;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] CTRL_WMASK  = 8'hff;
	// pin control register fields
	localparam int PC_GPIO_EN = 0;
	localparam int PC_A8_EN   = 1;
	localparam int PC_A9_EN   = 2;
	localparam int PC_CS_EN   = 3;
	localparam int PC_REQ_EN  = 4;
	localparam int PC_ACK_EN  = 5;
	localparam int PC_PORT_EN = 6;
	localparam int PC_REQ_OD  = 8;
	localparam int PC_DS_POL  = 9;
	localparam int PC_AS_POL  = 10;
	localparam int PC_MUX     = 11;
	localparam int PC_DUAL    = 12;
	localparam int PC_CS_POL  = 13;
	localparam int PC_REQ_POL = 14;
	localparam int PC_ACK_POL = 15;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] PC_WMASK = 16'hff7f;
	// status, irq status and irq mask share this layout
	localparam int ST_RX_FULL  = 0;
	localparam int ST_TX_EMPTY = 1;
	localparam int ST_CMD      = 2;
	localparam logic [2:0] ST_RESET = 3'h2;
	// dma mode codes
	localparam logic [2:0] DMA_OFF    = 3'h0;
	localparam logic [2:0] DMA_H2C_24 = 3'h1;
	localparam logic [2:0] DMA_H2C_16 = 3'h2;
	localparam logic [2:0] DMA_H2C_8  = 3'h3;
	localparam logic [2:0] DMA_ON     = 3'h4;
	localparam logic [2:0] DMA_C2H_24 = 3'h5;
	localparam logic [2:0] DMA_C2H_16 = 3'h6;
	localparam logic [2:0] DMA_C2H_8  = 3'h7;
	// winning interrupt source codes
	localparam logic [1:0] VEC_NONE = 2'h0;
	localparam logic [1:0] VEC_CMD  = 2'h1;
	localparam logic [1:0] VEC_RX   = 2'h2;
	localparam logic [1:0] VEC_TX   = 2'h3;
	// host side address map
	localparam logic HADDR_DATA  = 1'b0;
	localparam logic HADDR_FLAGS = 1'b1;
	localparam int   SYNC_W      = 17;
endpackage

// *** hw/hpc_sync3.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module hpc_sync3 #(
	parameter int W = 1
) (
	input  wire  logic         core_clk,
	input  wire  logic         rst_n,
	input  wire  logic [W-1:0] async_in,
	output var   logic [W-1:0] sync_out
);
	logic [W-1:0] ff1_reg;
	logic [W-1:0] ff2_reg;
	logic [W-1:0] ff3_reg;
	logic [W-1:0] sync_next;

	initial begin
		if (W < 1) $error("hpc_sync3: width must be at least 1");
	end

	// a bit moves only once stages two and three agree
	assign sync_next = (~(ff2_reg ^ ff3_reg) & ff2_reg) | ((ff2_reg ^ ff3_reg) & sync_out);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1_reg  <= '0;
			ff2_reg  <= '0;
			ff3_reg  <= '0;
			sync_out <= '0;
		end else begin
			ff1_reg  <= async_in;
			ff2_reg  <= ff1_reg;
			ff3_reg  <= ff2_reg;
			sync_out <= sync_next;
		end
	end
endmodule // hpc_sync3
`default_nettype wire

// *** hw/hpc_irq_prio.sv ***
// fixed priority picker for the three host interrupt sources
`timescale 1ns/1ns
`default_nettype none
module hpc_irq_prio (
	input  wire  logic [2:0] irq_req,
	output var   logic [1:0] irq_code
);
	// command beats receive, receive beats transmit
	assign irq_code = irq_req[hpc_pkg::ST_CMD]      ? hpc_pkg::VEC_CMD :
	                  irq_req[hpc_pkg::ST_RX_FULL]  ? hpc_pkg::VEC_RX  :
	                  irq_req[hpc_pkg::ST_TX_EMPTY] ? hpc_pkg::VEC_TX  : hpc_pkg::VEC_NONE;
endmodule // hpc_irq_prio
`default_nettype wire

// *** testbench/hpc_top_props.sv ***
// checker for the host port core-side block
`timescale 1ns/1ns
`default_nettype none
module hpc_top_props (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic        host_data_oe,
	input wire logic        host_request_oe,
	input wire logic [4:0]  pin_host_fn,
	input wire logic        port_gpio_enable
);
	logic [15:0] pc_reg;
	logic [1:0]  age_reg;
	logic        set_w;
	logic        ok_w;
	logic        en_w;
	logic        mux_w;
	assign set_w = avs_write && !avs_waitrequest && avs_address == hpc_pkg::OFS_PINCTRL;
	assign ok_w = age_reg == 2'h3;
	assign en_w = ok_w && pc_reg[hpc_pkg::PC_PORT_EN];
	assign mux_w = pc_reg[hpc_pkg::PC_MUX];
	// shadow of pin control, settled three cycles after each write
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pc_reg <= hpc_pkg::PC_RESET;
			age_reg <= 2'h0;
		end else if (set_w) begin
			pc_reg <= {avs_byteenable[1] ? avs_writedata[15:8] : pc_reg[15:8],
			           avs_byteenable[0] ? avs_writedata[7:0] : pc_reg[7:0]} & hpc_pkg::PC_WMASK;
			age_reg <= 2'h0;
		end else if (!ok_w) begin
			age_reg <= age_reg + 2'h1;
		end
	end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one cycle");
	accept_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus accept longer than one cycle");
	gpio_copy_a: assert property (ok_w |-> port_gpio_enable == pc_reg[0])
		else $error("gpio enable differs from pin control");
	gpio_force_a: assert property (ok_w && !pc_reg[6] |-> pin_host_fn == 5'h00)
		else $error("host function while port disabled");
	idle_pins_a: assert property (ok_w && !pc_reg[6] |-> !host_data_oe && !host_request_oe)
		else $error("pin driven while port disabled");
	addr_force_a: assert property (en_w && !mux_w |-> pin_host_fn[1:0] == 2'b11)
		else $error("address lines not forced on separate bus");
	addr_pick_a: assert property (en_w && mux_w |-> pin_host_fn[1:0] == pc_reg[2:1])
		else $error("address line enables wrong on shared bus");
	cs_req_a: assert property (en_w |-> pin_host_fn[3:2] == pc_reg[4:3])
		else $error("chip select or request enable wrong");
	ack_gate_a: assert property (en_w |-> pin_host_fn[4] == (pc_reg[5] && pc_reg[4]))
		else $error("ack enable not gated by request enable");
endmodule // hpc_top_props
bind hpc_top hpc_top_props u_hpc_top_props (
	.core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_waitrequest, .host_data_oe, .host_request_oe, .pin_host_fn, .port_gpio_enable
);
`default_nettype wire

// *** testbench/hpc_host_model.sv ***
// behavioural host processor on the parallel pins
`timescale 1ns/1ns
`default_nettype none
module hpc_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] host_data_out,
	input  wire logic       host_data_oe,
	output wire logic [7:0] host_data_in,
	output var  logic       host_addr_in,
	output var  logic       host_rw_in,
	output var  logic       chip_select_pin,
	output var  logic       addr_strobe_pin,
	output var  logic       data_strobe_pin,
	output var  logic       read_strobe_pin,
	output var  logic       write_strobe_pin,
	output var  logic       host_ack_in,
	output var  logic       host_cmd_in
);
	logic       act_lvl = 1'b0;
	logic       dual = 1'b0;
	logic [7:0] drv = 8'h00;
	logic       drv_on = 1'b0;
	// released data lines show the inverse of the last byte
	assign host_data_in = host_data_oe ? host_data_out : (drv_on ? drv : ~drv);
	task automatic idle();
		data_strobe_pin <= !act_lvl;
		read_strobe_pin <= !act_lvl;
		write_strobe_pin <= !act_lvl;
		host_ack_in <= 1'b1;
		chip_select_pin <= 1'b1;
	endtask
	task automatic mode(input logic lvl, input logic dl);
		act_lvl = lvl;
		dual = dl;
		idle();
	endtask
	task automatic cmd(input logic v);
		host_cmd_in <= v;
	endtask
	// one byte on the separate address/data bus, address 0 selects data
	task automatic xfer(input logic rd, input logic ack, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge core_clk);
		chip_select_pin <= 1'b0;
		host_addr_in <= 1'b0;
		host_rw_in <= rd;
		drv <= d;
		drv_on <= !rd;
		repeat (2) @(posedge core_clk);
		if (ack) host_ack_in <= 1'b0;
		else if (!dual) data_strobe_pin <= act_lvl;
		else if (rd) read_strobe_pin <= act_lvl;
		else write_strobe_pin <= act_lvl;
		repeat (8) @(posedge core_clk);
		q = host_data_in;
		idle();
		repeat (2) @(posedge core_clk);
		drv_on <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	initial begin
		host_addr_in = 1'b0;
		host_rw_in = 1'b0;
		host_cmd_in = 1'b0;
		addr_strobe_pin = 1'b1;
		idle();
	end
endmodule // hpc_host_model
`default_nettype wire

// *** testbench/hpc_top_bench.sv ***
// self-checking bench for the host port core-side block
`timescale 1ns/1ns
`default_nettype none
module hpc_top_bench;
	logic        core_clk, resetn, avs_read, avs_write;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	wire  logic [31:0] avs_readdata;
	wire  logic [7:0]  host_data_in, host_data_out;
	wire  logic [4:0]  pin_host_fn;
	wire  logic [1:0]  irq_vector;
	wire  logic  avs_waitrequest, host_data_oe, host_addr_in, host_rw_in, chip_select_pin;
	wire  logic  addr_strobe_pin, data_strobe_pin, read_strobe_pin, write_strobe_pin;
	wire  logic  host_ack_in, host_cmd_in, host_request_out, host_request_oe;
	wire  logic  port_gpio_enable, irq;
	int          err_count = 0;
	int          checked = 0;
	logic [31:0] q;
	logic [7:0]  hb;
	hpc_top u_hpc_top (
		.core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .host_data_in, .host_data_out,
		.host_data_oe, .host_addr_in, .host_rw_in, .chip_select_pin, .addr_strobe_pin,
		.data_strobe_pin, .read_strobe_pin, .write_strobe_pin, .host_ack_in, .host_cmd_in,
		.host_request_out, .host_request_oe, .pin_host_fn, .port_gpio_enable, .irq_vector,
		.irq
	);
	hpc_host_model u_hpc_host_model (
		.core_clk, .host_data_out, .host_data_oe, .host_data_in, .host_addr_in, .host_rw_in,
		.chip_select_pin, .addr_strobe_pin, .data_strobe_pin, .read_strobe_pin,
		.write_strobe_pin, .host_ack_in, .host_cmd_in
	);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic close_out();
		$display("mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(nm, e, q);
	endtask
	task automatic gap();
		repeat (4) @(posedge core_clk);
	endtask
	task automatic t_reset();
		rchk("ctrl", hpc_pkg::OFS_CTRL, 32'h0);
		rchk("pinctrl", hpc_pkg::OFS_PINCTRL, 32'h0);
		rchk("status", hpc_pkg::OFS_STATUS, 32'h2);
		bus(1'b1, 5'h1e, 32'hffffffff);
		rchk("unmapped", 5'h1e, 32'h0);
		avs_byteenable <= 4'h0;
		bus(1'b1, hpc_pkg::OFS_CTRL, 32'hff);
		avs_byteenable <= 4'hf;
		rchk("ctrl_no_lanes", hpc_pkg::OFS_CTRL, 32'h0);
	endtask
	task automatic t_pins();
		logic [15:0] v[4] = '{16'h087e, 16'h0049, 16'h00bf, 16'h0870};
		logic [4:0]  f[4] = '{5'h1f, 5'h07, 5'h00, 5'h18};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, hpc_pkg::OFS_PINCTRL, {16'h0, v[i]});
			rchk("pinctrl", hpc_pkg::OFS_PINCTRL, {16'h0, v[i] & hpc_pkg::PC_WMASK});
			gap();
			cmp("pin_fn", {27'h0, f[i]}, {27'h0, pin_host_fn});
			cmp("gpio_en", {31'h0, v[i][0]}, {31'h0, port_gpio_enable});
		end
	endtask
	task automatic t_dma();
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, hpc_pkg::OFS_CTRL, 32'(i << 5));
			rchk("dma", hpc_pkg::OFS_CTRL, 32'(i << 5));
		end
	endtask
	task automatic t_rx();
		logic [31:0] e;
		logic [7:0]  b;
		bus(1'b1, hpc_pkg::OFS_PINCTRL, 32'h0070);
		for (int m = 0; m < 4; m++) begin
			e = 32'h0;
			bus(1'b1, hpc_pkg::OFS_CTRL, 32'(m << 5));
			for (int k = 0; k < ((m == 0) ? 3 : 4 - m); k++) begin
				b = 8'(8'h1c * (k + 1) + m);
				u_hpc_host_model.xfer(1'b0, m != 0, b, hb);
				e = {e[23:0], b};
			end
			gap();
			rchk("status_full", hpc_pkg::OFS_STATUS, 32'h3);
			cmp("req_pins", 32'h3, {30'h0, host_request_oe, host_request_out});
			rchk("rxdata", hpc_pkg::OFS_RXDATA, e);
			rchk("status_read", hpc_pkg::OFS_STATUS, 32'h2);
			cmp("req_pins", 32'h2, {30'h0, host_request_oe, host_request_out});
		end
	endtask
	task automatic t_tx();
		bus(1'b1, hpc_pkg::OFS_CTRL, 32'h0);
		// strobe idle level changes only while the port is off
		bus(1'b1, hpc_pkg::OFS_PINCTRL, 32'h0);
		u_hpc_host_model.mode(1'b1, 1'b1);
		gap();
		bus(1'b1, hpc_pkg::OFS_PINCTRL, 32'h1270);
		bus(1'b1, hpc_pkg::OFS_TXDATA, 32'h00abcdef);
		rchk("status_tx", hpc_pkg::OFS_STATUS, 32'h0);
		for (int k = 0; k < 3; k++) begin
			u_hpc_host_model.xfer(1'b1, 1'b0, 8'h00, hb);
			cmp("host_rd", 32'h00abcdef >> (16 - 8 * k) & 32'hff, {24'h0, hb});
		end
		gap();
		rchk("status_empty", hpc_pkg::OFS_STATUS, 32'h2);
		bus(1'b1, hpc_pkg::OFS_CTRL, 32'he0);
		bus(1'b1, hpc_pkg::OFS_TXDATA, 32'h5c);
		u_hpc_host_model.xfer(1'b1, 1'b1, 8'h00, hb);
		cmp("dma_rd", 32'h5c, {24'h0, hb});
		bus(1'b1, hpc_pkg::OFS_PINCTRL, 32'h0);
		u_hpc_host_model.mode(1'b0, 1'b0);
		gap();
		bus(1'b1, hpc_pkg::OFS_PINCTRL, 32'h0040);
	endtask
	task automatic t_irq();
		bus(1'b1, hpc_pkg::OFS_IRQ_MASK, 32'h0);
		bus(1'b1, hpc_pkg::OFS_CTRL, 32'h07);
		u_hpc_host_model.cmd(1'b1);
		for (int k = 0; k < 3; k++) u_hpc_host_model.xfer(1'b0, 1'b0, 8'h5a, hb);
		rchk("irq_stat", hpc_pkg::OFS_IRQ_STAT, 32'h7);
		cmp("irq_masked", 32'h0, {31'h0, irq});
		cmp("vector", {30'h0, hpc_pkg::VEC_CMD}, {30'h0, irq_vector});
		bus(1'b1, hpc_pkg::OFS_IRQ_MASK, 32'h7);
		gap();
		cmp("irq_open", 32'h1, {31'h0, irq});
		u_hpc_host_model.cmd(1'b0);
		bus(1'b1, hpc_pkg::OFS_STATUS, 32'h4);
		gap();
		cmp("vector", {30'h0, hpc_pkg::VEC_RX}, {30'h0, irq_vector});
		rchk("rxdata", hpc_pkg::OFS_RXDATA, 32'h005a5a5a);
		gap();
		cmp("vector", {30'h0, hpc_pkg::VEC_TX}, {30'h0, irq_vector});
		bus(1'b1, hpc_pkg::OFS_IRQ_STAT, 32'h7);
		gap();
		cmp("irq_cleared", 32'h0, {31'h0, irq});
		bus(1'b1, hpc_pkg::OFS_TXDATA, 32'h1);
		gap();
		cmp("vector", {30'h0, hpc_pkg::VEC_NONE}, {30'h0, irq_vector});
	endtask
	initial begin
		#500000;
		err_count++;
		close_out();
	end
	initial begin
		resetn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_pins();
		t_dma();
		t_rx();
		t_tx();
		t_irq();
		close_out();
	end
endmodule // hpc_top_bench
`default_nettype wire
